//--- hw/uiec_pkg.sv
package uiec_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  ENABLE_SET_OFS   = 8'h10;
    localparam logic [7:0]  ENABLE_CLEAR_OFS = 8'h14;
    localparam logic [31:0] ENABLE_RESET     = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Field positions of the enable word
    // ------------------------------------------------------------------
    localparam int MASTER_IRQ_GATE_BIT        = 31;
    localparam int OWNER_CHANGE_EVENT_BIT     = 30;
    localparam int ROOT_PORT_CHANGE_EVENT_BIT = 6;
    localparam int FRAME_COUNT_WRAP_EVENT_BIT = 5;
    localparam int FATAL_FAULT_EVENT_BIT      = 4;
    localparam int RESUME_SEEN_EVENT_BIT      = 3;
    localparam int FRAME_BEGIN_EVENT_BIT      = 2;
    localparam int DONE_LIST_WRITTEN_EVENT_BIT = 1;
    localparam int SCHEDULE_OVERRUN_EVENT_BIT = 0;

    // Bits that hold state; all others are reserved and read as zero.
    localparam logic [31:0] ENABLE_IMPL_MASK = 32'hc000_007f;
    // Bits that gate a status flag, everything implemented except the master gate.
    localparam logic [31:0] EVENT_MASK       = 32'h4000_007f;

endpackage

//--- hw/uiec_gate_if.sv
`timescale 1ns/1ns
`default_nettype none
interface uiec_gate_if;
    logic [31:0] enable;
    logic [31:0] flags;
    logic        irq;

    modport src  (output enable, output flags, input irq);
    modport gate (input enable, input flags, output irq);
endinterface
`default_nettype wire

//--- hw/uiec_irq_gate.sv
`timescale 1ns/1ns
`default_nettype none
module uiec_irq_gate (
    input  wire logic   clk,
    input  wire logic   reset,
    uiec_gate_if.gate   gif
);
    import uiec_pkg::*;

    logic irq_q;
    logic irq_d;
    logic event_hit;

    // ------------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------------
    // The status flags are only read here, never written.
    assign event_hit = |(gif.flags & gif.enable & EVENT_MASK);
    assign irq_d     = event_hit & gif.enable[MASTER_IRQ_GATE_BIT];

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign gif.irq = irq_q;
endmodule
`default_nettype wire

//--- hw/uiec_top.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - Writing 1 to a clear-register bit clears that enable bit.
// - Writing 0 to a clear-register bit leaves that enable bit as it was.
// - Reading the clear register returns the live enable register.
// - The clear register is a 32-bit word at offset 14h.
// - Bit 31 clears the master gate, stopping every interrupt.
// - Bit 30 clears the ownership-change enable.
// - Bits 6 to 0 clear the seven per-event enables.
// - After reset all enables, the master gate included, are zero.
// - Interrupt asserts only for a set flag, its enable, and master gate.
// - The set register at 10h sets bits written 1, keeps bits written 0.
module uiec_top
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [31:0]       reg_wdata,
    output logic      [31:0]       reg_rdata,
    output logic                   reg_rvalid,
    input  wire logic [31:0]       interrupt_event_flags,
    output logic      [31:0]       interrupt_enable,
    output logic                   irq
);
    import uiec_pkg::*;

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
        $error("uiec_top: ADDR_W must be 5 to 32");
    end

    function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hits = (a == ADDR_W'(ofs));
    endfunction

    logic [31:0] enable_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        rvalid_q;
    logic        wr_set;
    logic        wr_clr;
    logic        rd_hit;
    logic [31:0] wmask;
    logic [31:0] enable_d;
    logic [31:0] clr_bit;
    logic [31:0] set_bit;
    logic        master_gate_en;
    logic        owner_chg_en;
    logic [6:0]  per_event_en;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    assign wr_set  = reg_wr & hits(reg_addr, ENABLE_SET_OFS);
    assign wr_clr  = reg_wr & hits(reg_addr, ENABLE_CLEAR_OFS);
    assign rd_hit  = hits(reg_addr, ENABLE_SET_OFS) | hits(reg_addr, ENABLE_CLEAR_OFS);
    // Reserved bits hold no state, so a stray 1 there is dropped.
    assign wmask   = reg_wdata & ENABLE_IMPL_MASK;
    // Both offsets read the one enable word; unmapped offsets read zero.
    assign rdata_d = rd_hit ? enable_q : 32'h0000_0000;

    // Per-bit write requests; one address per cycle keeps them disjoint.
    assign clr_bit = {32{wr_clr}} & wmask;
    assign set_bit = {32{wr_set}} & wmask;

    // Named views of the enable word for the checks below.
    assign master_gate_en = enable_q[MASTER_IRQ_GATE_BIT];
    assign owner_chg_en   = enable_q[OWNER_CHANGE_EVENT_BIT];
    assign per_event_en   = enable_q[ROOT_PORT_CHANGE_EVENT_BIT:SCHEDULE_OVERRUN_EVENT_BIT];

    // ------------------------------------------------------------------
    // Enable bits
    // ------------------------------------------------------------------
    // A clear takes priority over a set, although the two never meet.
    // Reserved positions take a constant zero and so never hold a 1.
    for (genvar i = 0; i < 32; i++) begin : g_en
        if (ENABLE_IMPL_MASK[i]) begin : g_impl
            assign enable_d[i] = clr_bit[i] ? 1'b0 :
                                 set_bit[i] ? 1'b1 :
                                 enable_q[i];
        end else begin : g_rsvd
            assign enable_d[i] = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            enable_q <= ENABLE_RESET;
        end else begin
            enable_q <= enable_d;
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // Read data is held until the next read, so a slow reader still sees it.
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q  <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= reg_rd ? rdata_d : rdata_q;
            rvalid_q <= reg_rd;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt gate
    // ------------------------------------------------------------------
    // Flags come from logic on this clock, so they need no synchroniser.
    uiec_gate_if gif ();
    assign gif.enable = enable_q;
    assign gif.flags  = interrupt_event_flags;

    uiec_irq_gate u_gate (
        .clk   (clk),
        .reset (reset),
        .gif   (gif)
    );

    assign reg_rdata        = rdata_q;
    assign reg_rvalid       = rvalid_q;
    assign interrupt_enable = enable_q;
    assign irq              = gif.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_CLEAR_ONES: assert property (wr_clr |=> (enable_q & $past(wmask)) == 32'h0)
        else $error("enable bit written 1 in clear register stayed set");
    AST_KEEP_ZEROS: assert property (wr_clr |=>
            enable_q == ($past(enable_q) & ~$past(wmask)))
        else $error("clear register changed a bit written 0");
    AST_READ_LIVE: assert property ((reg_rd && hits(reg_addr, ENABLE_CLEAR_OFS))
            |=> reg_rvalid && reg_rdata == $past(enable_q))
        else $error("clear register read did not return enable word");
    AST_MASTER_OFF: assert property ((wr_clr && reg_wdata[MASTER_IRQ_GATE_BIT])
            |=> !enable_q[MASTER_IRQ_GATE_BIT] ##1 !irq)
        else $error("master gate clear did not stop interrupt");
    AST_OWNER_OFF: assert property ((wr_clr && reg_wdata[OWNER_CHANGE_EVENT_BIT])
            |=> !enable_q[OWNER_CHANGE_EVENT_BIT])
        else $error("ownership change enable not cleared");
    AST_EVENTS_OFF: assert property (wr_clr |=>
            (enable_q[6:0] & $past(reg_wdata[6:0])) == 7'h00)
        else $error("per-event enable not cleared");
    // Reset checks run through reset, so they carry their own clocking.
    AST_RESET_ZERO: assert property (@(posedge clk) disable iff (1'b0)
            reset |=> enable_q == ENABLE_RESET && !irq)
        else $error("enables not zero after reset");
    // The request flop is cleared by reset, so the cycle after reset is exempt.
    AST_IRQ_CAUSE: assert property (!$past(reset) |->
            irq == $past(enable_q[MASTER_IRQ_GATE_BIT]
            && |(interrupt_event_flags & enable_q & EVENT_MASK)))
        else $error("interrupt request not matching flags and enables");
    AST_SET_ONES: assert property (wr_set |=>
            enable_q == ($past(enable_q) | $past(wmask)))
        else $error("set register did not set written bits");
    AST_WRITE_SPAN: assert property (reg_wr && !rd_hit |=> $stable(enable_q))
        else $error("write to other offset changed enables");
    AST_CLEAR_NO_SET: assert property (wr_clr |=>
            (enable_q & ~$past(enable_q)) == 32'h0)
        else $error("clear register set an enable bit");
    AST_IDLE_HOLD: assert property (!reg_wr
            |=> $stable(enable_q))
        else $error("enables changed without a write");
    AST_RSVD_ZERO: assert property (
            (enable_q & ~ENABLE_IMPL_MASK) == 32'h0)
        else $error("reserved enable bit is set");
    AST_OWNER_ONLY: assert property ((wr_clr && reg_wdata == 32'h4000_0000)
            |=> !owner_chg_en && master_gate_en == $past(master_gate_en)
            && per_event_en == $past(per_event_en))
        else $error("ownership change clear touched other enables");
    AST_EVENT_BITS: assert property ((wr_clr && reg_wdata == 32'h0000_007f)
            |=> per_event_en == 7'h00 && master_gate_en == $past(master_gate_en))
        else $error("per-event clear left an enable set or hit the master gate");
    AST_SET_NO_CLEAR: assert property (wr_set |=>
            ($past(enable_q) & ~enable_q) == 32'h0)
        else $error("set register cleared an enable bit");

    // ------------------------------------------------------------------
    // Interrupt and read port checks
    // ------------------------------------------------------------------
    AST_GATE_STOPS_IRQ: assert property (!master_gate_en
            |=> !irq)
        else $error("interrupt raised with master gate clear");
    AST_RVALID_PULSE: assert property (!$past(reset)
            |-> reg_rvalid == $past(reg_rd))
        else $error("read valid not one cycle after read strobe");
    AST_READ_SET_OFS: assert property ((reg_rd && hits(reg_addr, ENABLE_SET_OFS))
            |=> reg_rdata == $past(enable_q))
        else $error("set register read did not return enable word");
    AST_READ_OTHER: assert property ((reg_rd && !rd_hit)
            |=> reg_rdata == 32'h0)
        else $error("read of unmapped offset not zero");
    AST_RDATA_HOLD: assert property (!reg_rd
            |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    AST_RESET_OUTS: assert property (@(posedge clk) disable iff (1'b0)
            reset |=> !reg_rvalid && reg_rdata == 32'h0)
        else $error("read port not cleared by reset");

    COV_CLEAR_MASTER: cover property (wr_clr && reg_wdata[MASTER_IRQ_GATE_BIT]);
    COV_IRQ_THEN_OFF: cover property (irq ##1 wr_clr ##2 !irq);
    COV_READ_CLEAR:   cover property (reg_rd && hits(reg_addr, ENABLE_CLEAR_OFS)
            && enable_q != 32'h0);
    COV_OWNER_CLEAR:  cover property (wr_clr && reg_wdata[OWNER_CHANGE_EVENT_BIT]);
    COV_STRAY_WRITE:  cover property (reg_wr && !rd_hit);
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import uiec_pkg::*;
    logic        clk       = 1'b0;
    logic        reset     = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] flags     = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic [31:0] enable;
    logic        reg_rvalid;
    logic        irq;
    int          error_cnt   = 0;
    int          checks_done = 0;
    int          bits[9]     = '{31, 30, 6, 5, 4, 3, 2, 1, 0};

    always #5 clk = ~clk;

    uiec_top #(.ADDR_W(8)) u_dut (
        .clk                   (clk),
        .reset                 (reset),
        .reg_addr              (reg_addr),
        .reg_wr                (reg_wr),
        .reg_rd                (reg_rd),
        .reg_wdata             (reg_wdata),
        .reg_rdata             (reg_rdata),
        .reg_rvalid            (reg_rvalid),
        .interrupt_event_flags (flags),
        .interrupt_enable      (enable),
        .irq                   (irq)
    );

    // ------------------------------------------------------------------
    // Bus and compare tasks; each is entered one step after a rising edge.
    // ------------------------------------------------------------------
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        step();
        reg_wr    = 1'b0;
        step();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_addr = a;
        reg_rd   = 1'b1;
        step();
        reg_rd   = 1'b0;
        cmp("rvalid", 32'h0000_0001, {31'h0, reg_rvalid});
        cmp("rdata", exp, reg_rdata);
        step();
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_reset();
        flags = 32'h0000_0001;
        wr(ENABLE_SET_OFS, ENABLE_IMPL_MASK);
        rd(ENABLE_CLEAR_OFS, ENABLE_IMPL_MASK);
        cmp("irq", 32'h1, {31'h0, irq});
        reset = 1'b1;
        step();
        reset = 1'b0;
        cmp("enable", ENABLE_RESET, enable);
        cmp("irq", 32'h0, {31'h0, irq});
        cmp("rdata", 32'h0, reg_rdata);
        cmp("rvalid", 32'h0, {31'h0, reg_rvalid});
        step();
        cmp("irq", 32'h0, {31'h0, irq});
        flags = 32'h0000_0000;
        rd(ENABLE_CLEAR_OFS, ENABLE_RESET);
        $display("test reset done");
    endtask

    task automatic t_set_read();
        wr(ENABLE_SET_OFS, ENABLE_IMPL_MASK);
        cmp("enable", 32'hc000_007f, enable);
        rd(ENABLE_CLEAR_OFS, 32'hc000_007f);
        rd(ENABLE_SET_OFS, 32'hc000_007f);
        wr(ENABLE_CLEAR_OFS, 32'h0000_0000);
        rd(ENABLE_CLEAR_OFS, 32'hc000_007f);
        $display("test set and read done");
    endtask

    task automatic t_clear_bits();
        foreach (bits[i]) begin
            wr(ENABLE_SET_OFS, ENABLE_IMPL_MASK);
            wr(ENABLE_CLEAR_OFS, 32'h1 << bits[i]);
            cmp("enable", ENABLE_IMPL_MASK & ~(32'h1 << bits[i]), enable);
        end
        wr(ENABLE_CLEAR_OFS, 32'h8000_0000);
        wr(ENABLE_CLEAR_OFS, 32'h4000_0001);
        cmp("enable", 32'h0000_007e, enable);
        wr(ENABLE_CLEAR_OFS, 32'h0000_007f);
        cmp("enable", 32'h0000_0000, enable);
        $display("test clear bits done");
    endtask

    task automatic t_irq();
        wr(ENABLE_SET_OFS, ENABLE_IMPL_MASK);
        flags = 32'h0000_0008;
        step();
        cmp("irq", 32'h1, {31'h0, irq});
        wr(ENABLE_CLEAR_OFS, 32'h8000_0000);
        step();
        cmp("irq", 32'h0, {31'h0, irq});
        wr(ENABLE_SET_OFS, 32'h8000_0000);
        wr(ENABLE_CLEAR_OFS, 32'h0000_0008);
        step();
        cmp("irq", 32'h0, {31'h0, irq});
        flags = 32'h0000_0000;
        $display("test irq done");
    endtask

    task automatic t_unmapped();
        wr(8'h18, 32'hffff_ffff);
        cmp("enable", 32'hc000_0077, enable);
        rd(8'h18, 32'h0000_0000);
        $display("test unmapped done");
    endtask

    initial begin
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
        t_reset();
        t_set_read();
        t_clear_bits();
        t_irq();
        t_unmapped();
        report_and_stop();
    end
endmodule
`default_nettype wire
